// ---- inc/scs_regs.svh ----
// System clock selector register map, field positions, reset values and counts
// Operation
// R1: Out of reset run from the fast RC at 12MHz; crystal pads stay GPIO.
// R2: Software may change the oscillator input at any time without a reset.
// R3: A two-bit select field chooses which of four sources feeds the oscillator input.
// R4: Software waits for a new source to settle before switching to it.
// R5: Crystal mode turns P6.0/P6.1 into crystal output/input and blocks their GPIO use.
// R6: External clock mode takes the oscillator input from P6.0; P6.1 stays GPIO.
// R7: Hardware sets the read-only crystal ready flag once the crystal is stable.
// R8: Software polls crystal ready before switching the oscillator input to the crystal.
// R9: Fast RC runs at 12MHz or 11.059MHz, chosen by the alternate frequency bit.
// R10: In RC modes P6.0 can output master clock, master/2 or master/4.
// R11: Slow RC of about 32KHz feeds the watchdog and may be the system source.
// R12: Software sets the multiplier input divider for about 6MHz before enabling it.
// R13: Multiplier gives x4, x5.33 or x8; master source field picks the output.
// R14: System clock comes from the master clock through a three-bit select divider.
// R15: Software keeps system and CPU clocks at or below 25MHz.
// R16: Counter array gets a doubled master clock and a x16 multiplier clock.
// R17: Software lowers the system divider before raising multiplier output.
// R18: Divider codes 000 to 111 divide the master clock by 1 up to 128.
// R19: Source codes: 00 fast RC, 01 crystal, 10 slow RC, 11 external pin.
// R20: CPU clock equals system clock when the halve bit is clear, half when set.
// R21: Master codes: 00 oscillator input, 01 x4, 10 x5.33, 11 x8; multiplier enabled.
// R22: Source and divider changes never shorten a clock phase.
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH
`define SCS_ADDR_CTRL0 12'h000
`define SCS_ADDR_CTRL1 12'h004
`define SCS_ADDR_CTRL2 12'h008
`define SCS_ADDR_PINCTL 12'h00c
`define SCS_ADDR_STATUS 12'h010
`define SCS_CTRL0_RST 8'h10
`define SCS_CTRL1_RST 6'h0b
`define SCS_CTRL2_RST 8'h50
`define SCS_PINCTL_RST 2'h0
`define SCS_ALT_BIT 7
`define SCS_MULT_EN_BIT 6
`define SCS_MULIN_MSB 5
`define SCS_MULIN_LSB 4
`define SCS_CPU_HALF_BIT 3
`define SCS_SYSDIV_MSB 2
`define SCS_XTAL_READY_BIT 7
`define SCS_XTAL_EN_BIT 5
`define SCS_FRC_EN_BIT 4
`define SCS_MCLK_MSB 3
`define SCS_MCLK_LSB 2
`define SCS_OSC_MSB 1
`define SCS_XTAL_STARTUP 11'h400
`define SCS_RATIO_X2 9'h020
`define SCS_RATIO_X4 9'h040
`define SCS_RATIO_X533 9'h055
`define SCS_RATIO_X8 9'h080
`define SCS_RATIO_X16 9'h100
`define SCS_MULIN_LIM_D1 3'h0
`define SCS_MULIN_LIM_D2 3'h1
`define SCS_MULIN_LIM_D4 3'h3
`define SCS_MULIN_LIM_D6 3'h5
`endif

// ---- inc/scs_pkg.sv ----
// Types shared by the system clock selector modules
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_OSC_FAST = 2'b00,
        SCS_OSC_XTAL = 2'b01,
        SCS_OSC_SLOW = 2'b10,
        SCS_OSC_EXT = 2'b11
    } scs_osc_sel_t;
    typedef enum logic [1:0] {
        SCS_MCLK_OSC = 2'b00,
        SCS_MCLK_X4 = 2'b01,
        SCS_MCLK_X533 = 2'b10,
        SCS_MCLK_X8 = 2'b11
    } scs_mclk_sel_t;
    typedef enum logic [1:0] {
        SCS_PIN_GPIO = 2'b00,
        SCS_PIN_MCLK = 2'b01,
        SCS_PIN_MCLK2 = 2'b10,
        SCS_PIN_MCLK4 = 2'b11
    } scs_pin_mode_t;
endpackage

// ---- inc/scs_nco_if.sv ----
// Link between the clock selector and its rate multiplier instances
`timescale 1ns/100ps
`default_nettype none
interface scs_nco_if;
    logic in_tick;
    logic [8:0] ratio;
    logic out_tick;
    modport src (output in_tick, output ratio, input out_tick);
    modport nco (input in_tick, input ratio, output out_tick);
endinterface
`default_nettype wire

// ---- hw/scs_nco.sv ----
// Rate multiplier: measures the input tick period and emits ticks at ratio/16 times the input tick rate
`timescale 1ns/100ps
`default_nettype none
module scs_nco (
    input wire logic pclk,
    input wire logic presetn,
    scs_nco_if.nco port_if
);
    logic [15:0] per_cnt_r;
    logic [15:0] per_r;
    logic [20:0] acc_r;
    logic out_r;
    logic [20:0] sum;
    logic [20:0] limit;

    assign limit = {1'b0, per_r, 4'h0};
    assign sum = acc_r + {12'h000, port_if.ratio};
    assign port_if.out_tick = out_r;

    // Period is re-measured on every input tick, so the output tracks a drifting source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt_r <= 16'h0000;
            per_r <= 16'h0000;
        end else if (port_if.in_tick) begin
            per_r <= per_cnt_r + 16'h0001;
            per_cnt_r <= 16'h0000;
        end else if (per_cnt_r != 16'hffff) begin
            per_cnt_r <= per_cnt_r + 16'h0001;
        end
    end

    // Until a period is known nothing comes out: no early runt ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= 21'h000000;
            out_r <= 1'b0;
        end else if (per_r == 16'h0000) begin
            acc_r <= 21'h000000;
            out_r <= 1'b0;
        end else if (sum >= limit) begin
            acc_r <= sum - limit;
            out_r <= 1'b1;
        end else begin
            acc_r <= sum;
            out_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- hw/scs_top.sv ----
// System clock selector: source select, multiplier, dividers, crystal pads, APB registers
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "scs_regs.svh"
module scs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_rc_tick,
    input wire logic slow_rc_tick,
    input wire logic p60_in,
    output logic p60_out,
    output logic p60_oe,
    input wire logic p61_in,
    output logic p61_out,
    output logic p61_oe,
    input wire logic gpio_p60_out,
    input wire logic gpio_p60_oe,
    input wire logic gpio_p61_out,
    input wire logic gpio_p61_oe,
    output logic gpio_p60_in,
    output logic gpio_p61_in,
    output logic fast_rc_enable,
    output logic alt_frequency_select,
    output logic crystal_enable,
    output logic clock_multiplier_enable,
    output logic master_clock_tick,
    output logic system_clock_tick,
    output logic cpu_core_clock_tick,
    output logic doubled_master_clock_tick,
    output logic multiplier_x16_clock_tick,
    output logic watchdog_tick
);
    logic [7:0] ctrl0_r;
    logic [5:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    logic [1:0] pinctl_r;
    logic [31:0] prdata_r;
    logic [10:0] xtal_cnt_r;
    logic crystal_ready_flag_r;
    logic p61_q_r;
    logic p60_q_r;
    scs_pkg::scs_osc_sel_t active_osc_r;
    scs_pkg::scs_mclk_sel_t active_mclk_r;
    logic osc_tick_r;
    logic [2:0] mulin_cnt_r;
    logic mulin_tick_r;
    logic mclk_tick_r;
    logic [6:0] div_cnt_r;
    logic [2:0] active_div_r;
    logic sys_tick_r;
    logic cpu_half_r;
    logic cpu_phase_r;
    logic cpu_tick_r;
    logic [1:0] pin_cnt_r;
    logic pin_level_r;
    logic wdog_tick_r;
    logic p60_out_r, p60_oe_r, p61_out_r, p61_oe_r;
    logic wr_en, setup, mapped;
    logic [3:0] src_tick;
    scs_pkg::scs_osc_sel_t req_osc;
    scs_pkg::scs_mclk_sel_t req_mclk;
    scs_pkg::scs_pin_mode_t pin_mode;
    logic osc_switch, mclk_switch;
    logic [2:0] mulin_lim;
    logic [6:0] div_lim;
    logic rc_mode, clk_out_on;

    scs_nco_if mult_if ();
    scs_nco_if x16_if ();
    scs_nco_if dbl_if ();

    scs_nco u_mult (.pclk(pclk), .presetn(presetn), .port_if(mult_if.nco));
    scs_nco u_x16 (.pclk(pclk), .presetn(presetn), .port_if(x16_if.nco));
    scs_nco u_dbl (.pclk(pclk), .presetn(presetn), .port_if(dbl_if.nco));

    // APB slave: zero wait states, read data latched in the setup cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign mapped = (paddr == `SCS_ADDR_CTRL0) || (paddr == `SCS_ADDR_CTRL1) || (paddr == `SCS_ADDR_CTRL2) ||
                    (paddr == `SCS_ADDR_PINCTL) || (paddr == `SCS_ADDR_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_r <= `SCS_CTRL0_RST;
            ctrl1_r <= `SCS_CTRL1_RST;
            ctrl2_r <= `SCS_CTRL2_RST;
            pinctl_r <= `SCS_PINCTL_RST;
        end else if (wr_en) begin
            case (paddr)
                `SCS_ADDR_CTRL0: ctrl0_r <= pwdata[7:0];
                `SCS_ADDR_CTRL1: ctrl1_r <= pwdata[5:0];
                `SCS_ADDR_CTRL2: ctrl2_r <= pwdata[7:0]; // R2 R3
                `SCS_ADDR_PINCTL: pinctl_r <= pwdata[1:0];
                default: ctrl0_r <= ctrl0_r;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (setup) begin
            case (paddr)
                `SCS_ADDR_CTRL0: prdata_r <= {24'h000000, ctrl0_r};
                `SCS_ADDR_CTRL1: prdata_r <= {24'h000000, crystal_ready_flag_r, 1'b0, ctrl1_r}; // R7
                `SCS_ADDR_CTRL2: prdata_r <= {24'h000000, ctrl2_r};
                `SCS_ADDR_PINCTL: prdata_r <= {30'h00000000, pinctl_r};
                `SCS_ADDR_STATUS: prdata_r <= {24'h000000, cpu_half_r, active_div_r, active_mclk_r, active_osc_r};
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    assign fast_rc_enable = ctrl2_r[`SCS_FRC_EN_BIT];
    assign alt_frequency_select = ctrl0_r[`SCS_ALT_BIT]; // R9
    assign crystal_enable = ctrl2_r[`SCS_XTAL_EN_BIT];
    assign clock_multiplier_enable = ctrl0_r[`SCS_MULT_EN_BIT];
    assign req_osc = scs_pkg::scs_osc_sel_t'(ctrl2_r[`SCS_OSC_MSB:0]);
    assign req_mclk = clock_multiplier_enable ? scs_pkg::scs_mclk_sel_t'(ctrl2_r[`SCS_MCLK_MSB:`SCS_MCLK_LSB])
                                              : scs_pkg::SCS_MCLK_OSC; // R21
    assign pin_mode = scs_pkg::scs_pin_mode_t'(pinctl_r);

    // Crystal start-up: count crystal input edges while the amplifier runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p61_q_r <= 1'b0;
            p60_q_r <= 1'b0;
        end else begin
            p61_q_r <= p61_in;
            p60_q_r <= p60_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_cnt_r <= 11'h000;
            crystal_ready_flag_r <= 1'b0;
        end else if (!crystal_enable) begin
            xtal_cnt_r <= 11'h000;
            crystal_ready_flag_r <= 1'b0;
        end else if (p61_in && !p61_q_r && !crystal_ready_flag_r) begin
            xtal_cnt_r <= xtal_cnt_r + 11'h001;
            crystal_ready_flag_r <= (xtal_cnt_r == `SCS_XTAL_STARTUP - 11'h001); // R7
        end
    end

    // One tick per source edge; index is the select code
    assign src_tick[scs_pkg::SCS_OSC_FAST] = fast_rc_tick && fast_rc_enable;
    assign src_tick[scs_pkg::SCS_OSC_XTAL] = p61_in && !p61_q_r && crystal_ready_flag_r;
    assign src_tick[scs_pkg::SCS_OSC_SLOW] = slow_rc_tick; // R11
    assign src_tick[scs_pkg::SCS_OSC_EXT] = p60_in && !p60_q_r; // R6

    // Hand over only on the new source's own edge; a source that never ticks keeps the old one
    assign osc_switch = (req_osc != active_osc_r) && src_tick[req_osc]; // R4 R8 R22

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_osc_r <= scs_pkg::SCS_OSC_FAST; // R1
            osc_tick_r <= 1'b0;
        end else if (osc_switch) begin
            active_osc_r <= req_osc; // R2 R19
            osc_tick_r <= 1'b1;
        end else begin
            osc_tick_r <= src_tick[active_osc_r]; // R3 R19
        end
    end

    // Multiplier input divider by 1, 2, 4 or 6
    always_comb begin
        case (ctrl0_r[`SCS_MULIN_MSB:`SCS_MULIN_LSB])
            2'b00: mulin_lim = `SCS_MULIN_LIM_D1;
            2'b01: mulin_lim = `SCS_MULIN_LIM_D2;
            2'b10: mulin_lim = `SCS_MULIN_LIM_D4;
            default: mulin_lim = `SCS_MULIN_LIM_D6;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mulin_cnt_r <= 3'h0;
            mulin_tick_r <= 1'b0;
        end else if (osc_tick_r) begin
            mulin_tick_r <= (mulin_cnt_r >= mulin_lim); // R12
            mulin_cnt_r <= (mulin_cnt_r >= mulin_lim) ? 3'h0 : mulin_cnt_r + 3'h1;
        end else begin
            mulin_tick_r <= 1'b0;
        end
    end

    assign mult_if.in_tick = mulin_tick_r && clock_multiplier_enable;
    assign x16_if.in_tick = mulin_tick_r && clock_multiplier_enable;
    assign x16_if.ratio = `SCS_RATIO_X16; // R16
    always_comb begin
        case (req_mclk)
            scs_pkg::SCS_MCLK_X4: mult_if.ratio = `SCS_RATIO_X4; // R13
            scs_pkg::SCS_MCLK_X533: mult_if.ratio = `SCS_RATIO_X533;
            default: mult_if.ratio = `SCS_RATIO_X8;
        endcase
    end

    // Master clock follows the same edge-aligned hand-over as the oscillator input
    assign mclk_switch = (req_mclk != active_mclk_r) &&
                         ((req_mclk == scs_pkg::SCS_MCLK_OSC) ? osc_tick_r : mult_if.out_tick);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_mclk_r <= scs_pkg::SCS_MCLK_OSC;
            mclk_tick_r <= 1'b0;
        end else if (mclk_switch) begin
            active_mclk_r <= req_mclk; // R13 R21 R22
            mclk_tick_r <= 1'b1;
        end else begin
            mclk_tick_r <= (active_mclk_r == scs_pkg::SCS_MCLK_OSC) ? osc_tick_r : mult_if.out_tick;
        end
    end

    assign dbl_if.in_tick = mclk_tick_r;
    assign dbl_if.ratio = `SCS_RATIO_X2; // R16

    // System divider: a new ratio takes effect only at the end of a full period
    assign div_lim = 7'(({1'b0, 7'h01} << active_div_r) - 8'h01); // R18

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 7'h00;
            active_div_r <= 3'h0;
            sys_tick_r <= 1'b0;
        end else if (mclk_tick_r) begin
            if (div_cnt_r >= div_lim) begin
                div_cnt_r <= 7'h00;
                sys_tick_r <= 1'b1; // R14
                active_div_r <= ctrl0_r[`SCS_SYSDIV_MSB:0]; // R15 R17 R22
            end else begin
                div_cnt_r <= div_cnt_r + 7'h01;
                sys_tick_r <= 1'b0;
            end
        end else begin
            sys_tick_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_half_r <= 1'b0;
            cpu_phase_r <= 1'b0;
            cpu_tick_r <= 1'b0;
        end else if (sys_tick_r) begin
            cpu_tick_r <= !cpu_half_r || cpu_phase_r; // R20
            if (!cpu_half_r || cpu_phase_r) begin
                cpu_half_r <= ctrl0_r[`SCS_CPU_HALF_BIT]; // R22
                cpu_phase_r <= 1'b0;
            end else begin
                cpu_phase_r <= 1'b1;
            end
        end else begin
            cpu_tick_r <= 1'b0;
        end
    end

    // Master clock out on P6.0; the x1 mode is a tick pulse since the master clock exists only as an enable
    assign rc_mode = (active_osc_r == scs_pkg::SCS_OSC_FAST) || (active_osc_r == scs_pkg::SCS_OSC_SLOW);
    assign clk_out_on = rc_mode && !crystal_enable && (req_osc != scs_pkg::SCS_OSC_EXT) &&
                        (pin_mode != scs_pkg::SCS_PIN_GPIO);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_cnt_r <= 2'h0;
            pin_level_r <= 1'b0;
        end else begin
            if (mclk_tick_r) begin
                pin_cnt_r <= pin_cnt_r + 2'h1;
            end
            case (pin_mode)
                scs_pkg::SCS_PIN_MCLK: pin_level_r <= mclk_tick_r; // R10
                scs_pkg::SCS_PIN_MCLK2: pin_level_r <= pin_cnt_r[0];
                scs_pkg::SCS_PIN_MCLK4: pin_level_r <= pin_cnt_r[1];
                default: pin_level_r <= 1'b0;
            endcase
        end
    end

    // Pad ownership; crystal mode inverts the input onto the output like the amplifier
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p60_out_r <= 1'b0;
            p60_oe_r <= 1'b0;
            p61_out_r <= 1'b0;
            p61_oe_r <= 1'b0;
        end else if (crystal_enable) begin
            p60_out_r <= !p61_in; // R5
            p60_oe_r <= 1'b1;
            p61_out_r <= 1'b0;
            p61_oe_r <= 1'b0;
        end else begin
            p61_out_r <= gpio_p61_out; // R1 R6
            p61_oe_r <= gpio_p61_oe;
            if (req_osc == scs_pkg::SCS_OSC_EXT || active_osc_r == scs_pkg::SCS_OSC_EXT) begin
                p60_out_r <= 1'b0; // R6
                p60_oe_r <= 1'b0;
            end else if (clk_out_on) begin
                p60_out_r <= pin_level_r; // R10
                p60_oe_r <= 1'b1;
            end else begin
                p60_out_r <= gpio_p60_out;
                p60_oe_r <= gpio_p60_oe;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_tick_r <= 1'b0;
        end else begin
            wdog_tick_r <= slow_rc_tick; // R11
        end
    end

    assign p60_out = p60_out_r;
    assign p60_oe = p60_oe_r;
    assign p61_out = p61_out_r;
    assign p61_oe = p61_oe_r;
    assign gpio_p60_in = crystal_enable ? 1'b0 : p60_in; // R5
    assign gpio_p61_in = crystal_enable ? 1'b0 : p61_in;
    assign master_clock_tick = mclk_tick_r;
    assign system_clock_tick = sys_tick_r;
    assign cpu_core_clock_tick = cpu_tick_r;
    assign doubled_master_clock_tick = dbl_if.out_tick;
    assign multiplier_x16_clock_tick = x16_if.out_tick;
    assign watchdog_tick = wdog_tick_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    boot_fast_rc_a: assert property (!$past(presetn) |-> active_osc_r == scs_pkg::SCS_OSC_FAST && !p60_oe_r) // R1
        else $error("not on fast RC after reset");
    osc_follow_a: assert property (osc_switch |=> active_osc_r == $past(req_osc) && osc_tick_r) // R2
        else $error("oscillator input did not follow the select");
    osc_map_a: assert property (!osc_switch |=> osc_tick_r == $past(src_tick[active_osc_r])) // R3
        else $error("oscillator tick not from the selected source");
    xtal_pins_a: assert property (crystal_enable && $past(crystal_enable) |-> p60_oe && !p61_oe && !gpio_p61_in) // R5
        else $error("crystal pads not owned by the crystal");
    ext_pin_a: assert property (!crystal_enable && req_osc == scs_pkg::SCS_OSC_EXT |=> !p60_oe || crystal_enable) // R6
        else $error("P6.0 driven in external clock mode");
    xtal_ready_a: assert property (!crystal_enable |=> !crystal_ready_flag_r) // R7
        else $error("crystal ready without crystal enabled");
    wdog_tick_a: assert property (slow_rc_tick |=> watchdog_tick) // R11
        else $error("watchdog tick lost");
    mclk_osc_a: assert property (active_mclk_r == scs_pkg::SCS_MCLK_OSC && !mclk_switch // R21
        |=> mclk_tick_r == $past(osc_tick_r))
        else $error("master clock not from oscillator input");
    div_one_a: assert property (active_div_r == 3'h0 && mclk_tick_r |=> sys_tick_r) // R18
        else $error("divide by one dropped a tick");
    div_gap_a: assert property (active_div_r == 3'h1 && sys_tick_r |=> !sys_tick_r) // R14
        else $error("divider gap wrong");
    cpu_full_a: assert property (!cpu_half_r && sys_tick_r |=> cpu_tick_r) // R20
        else $error("CPU clock not equal to system clock");
    cpu_half_a: assert property (cpu_half_r && sys_tick_r && !cpu_phase_r |=> !cpu_tick_r) // R20
        else $error("CPU clock not halved");
endmodule
`default_nettype wire

// ---- tb/scs_src_model.sv ----
// Far-side clock sources: RC oscillator ticks, crystal and external clock pads
`timescale 1ns/100ps
`default_nettype none
module scs_src_model (
    input wire logic pclk,
    input wire logic crystal_enable,
    input wire logic ext_run,
    output logic fast_rc_tick,
    output logic slow_rc_tick,
    output logic p60_in,
    output logic p61_in
);
    logic [7:0] cnt_r = 8'h00;
    always @(posedge pclk) cnt_r <= cnt_r + 8'h01;
    assign fast_rc_tick = cnt_r[2:0] == 3'h0;
    assign slow_rc_tick = cnt_r == 8'h00;
    // Crystal swings only while its amplifier is enabled
    assign p61_in = crystal_enable & cnt_r[1];
    assign p60_in = ext_run & cnt_r[3];
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the system clock selector
`timescale 1ns/100ps
`default_nettype none
`include "scs_regs.svh"
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdata;
    logic rerr;
    logic gpio_p60_out = 1'b0;
    logic gpio_p60_oe = 1'b0;
    logic gpio_p61_out = 1'b1;
    logic gpio_p61_oe = 1'b1;
    logic ext_run = 1'b0;
    logic pready, pslverr, fast_rc_tick, slow_rc_tick, p60_in, p61_in, p60_out, p60_oe, p61_out, p61_oe;
    logic gpio_p60_in, gpio_p61_in, fast_rc_enable, alt_frequency_select, crystal_enable;
    logic clock_multiplier_enable, master_clock_tick, system_clock_tick, cpu_core_clock_tick;
    logic doubled_master_clock_tick, multiplier_x16_clock_tick, watchdog_tick;
    logic [2:0] tk;
    logic slow_d = 1'b0;
    int bad_count = 0;
    int checks = 0;
    int mclk_n = 0;
    int mclk_per = 0;
    int sys_n = 0;
    int sys_per = 0;
    int cyc [3];
    int gap [3];
    assign tk = {multiplier_x16_clock_tick, doubled_master_clock_tick, master_clock_tick};
    scs_top dut_u (.*);
    scs_src_model src_u (.*);
    always #5 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Tick spacing monitors: master per system tick, system per cpu tick, cycles between ticks
    always @(posedge pclk) begin
        slow_d <= slow_rc_tick;
        if (presetn) chk(watchdog_tick, slow_d);
        mclk_n <= system_clock_tick ? 0 : mclk_n + master_clock_tick;
        if (system_clock_tick) mclk_per <= mclk_n + master_clock_tick;
        sys_n <= cpu_core_clock_tick ? 0 : sys_n + system_clock_tick;
        if (cpu_core_clock_tick) sys_per <= sys_n + system_clock_tick;
        for (int i = 0; i < 3; i++) begin
            cyc[i] <= tk[i] ? 1 : cyc[i] + 1;
            if (tk[i]) gap[i] <= cyc[i];
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(pready, 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic nsys(input int n);
        int k;
        k = 0;
        while (n > 0 && k < 20000) begin
            @(posedge pclk);
            k++;
            if (system_clock_tick === 1'b1) n--;
        end
        chk(n, 0);
    endtask
    task automatic setsrc(input logic [31:0] v, input logic [31:0] st, input int g);
        apb(1'b1, `SCS_ADDR_CTRL2, v);
        repeat (800) @(posedge pclk);
        rd(`SCS_ADDR_STATUS);
        chk(rdata, st);
        if (g > 0) chk(gap[0], g);
    endtask
    task automatic t_reset();
        rd(`SCS_ADDR_CTRL0);
        chk(rdata, 32'h10);
        rd(`SCS_ADDR_CTRL1);
        chk(rdata, 32'h0b);
        rd(`SCS_ADDR_CTRL2);
        chk(rdata, 32'h50);
        chk(fast_rc_enable, 1'b1);
        chk(p61_oe, 1'b1);
        rd(12'h014);
        chk(rerr, 1'b1);
        chk(rdata, 32'h0);
    endtask
    task automatic t_div();
        for (int c = 0; c < 9; c++) begin
            apb(1'b1, `SCS_ADDR_CTRL0, 32'h10 | c);
            nsys(6);
            chk(mclk_per, 1 << (c % 8));
            chk(sys_per, 1 + c / 8);
            chk(gap[0], 8);
            rd(`SCS_ADDR_STATUS);
            chk(rdata, ((c / 8) << 7) | ((c % 8) << 4));
        end
    endtask
    task automatic t_src();
        int n;
        n = 0;
        apb(1'b1, `SCS_ADDR_CTRL2, 32'h70);
        wait (p61_in === 1'b1);
        #1;
        chk(gpio_p61_in, 1'b0);
        chk(crystal_enable, 1'b1);
        do begin
            rd(`SCS_ADDR_CTRL1);
            n++;
        end while (rdata[7] !== 1'b1 && n < 3000);
        chk(rdata, 32'h8b);
        setsrc(32'h71, 32'h81, 4);
        chk(p61_oe, 1'b0);
        setsrc(32'h72, 32'h82, 256);
        ext_run <= 1'b1;
        setsrc(32'h53, 32'h83, 16);
        chk(p60_oe, 1'b0);
        chk(p61_oe, 1'b1);
        chk(p61_out, 1'b1);
        chk(gpio_p60_in, p60_in);
        rd(`SCS_ADDR_CTRL1);
        chk(rdata, 32'h0b);
        setsrc(32'h50, 32'h80, 8);
        ext_run <= 1'b0;
    endtask
    task automatic t_mult();
        apb(1'b1, `SCS_ADDR_CTRL0, 32'h11);
        apb(1'b1, `SCS_ADDR_CTRL0, 32'hd1);
        setsrc(32'h5c, 32'h1c, 2);
        chk(alt_frequency_select, 1'b1);
        chk(clock_multiplier_enable, 1'b1);
        chk(gap[1], 1);
        chk(gap[2], 1);
        setsrc(32'h54, 32'h14, 4);
        chk(gap[1], 2);
        setsrc(32'h58, 32'h18, 0);
        setsrc(32'h50, 32'h10, 8);
    endtask
    task automatic t_pin();
        for (int m = 3; m >= 0; m--) begin
            apb(1'b1, `SCS_ADDR_PINCTL, m);
            repeat (2) @(posedge pclk);
            chk(p60_oe, m != 0);
            if (m == 1) begin
                @(posedge pclk iff master_clock_tick === 1'b1);
                repeat (2) @(negedge pclk);
                chk(p60_out, 1'b1);
            end
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_div();
        t_src();
        t_mult();
        t_pin();
        wrap_up();
    end
    initial begin
        #600000;
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
